// ==== hw/rcc_pkg.sv ====
package rcc_pkg;
	// Register location on the special-function bus
	localparam logic [7:0] CTRL_ADDR = 8'h97;
	localparam logic [3:0] CTRL_PAGE = 4'h0;
	localparam logic [7:0] CTRL_RESET = 8'h03;
	// Field positions
	localparam int SRC_SEL_BIT = 7;
	localparam int DIV_HI = 6;
	localparam int DIV_LO = 5;
	localparam int SAR_INV_BIT = 4;
	localparam int DIV_IN_INV_BIT = 3;
	localparam int SYNC_EN_BIT = 2;
	localparam int MINPW_HI = 1;
	localparam int MINPW_LO = 0;
	// Divide select codes and ratios
	localparam logic [1:0] DIV_CODE_4 = 2'h2;
	localparam logic [1:0] DIV_CODE_8 = 2'h3;
	localparam logic [3:0] DIV_RATIO_1 = 4'h1;
	localparam logic [3:0] DIV_RATIO_4 = 4'h4;
	localparam logic [3:0] DIV_RATIO_8 = 4'h8;
	// Minimum pulse width codes and widths in ns
	localparam logic [1:0] MINPW_OFF = 2'h0;
	localparam logic [1:0] MINPW_CODE_10 = 2'h1;
	localparam logic [1:0] MINPW_CODE_20 = 2'h2;
	localparam logic [7:0] MINPW_10_NS = 8'h0a;
	localparam logic [7:0] MINPW_20_NS = 8'h14;
	localparam logic [7:0] MINPW_40_NS = 8'h28;
	localparam logic [7:0] MINPW_NONE_NS = 8'h00;
endpackage

// ==== hw/rcc_pulse_skip.sv ====
module rcc_pulse_skip #(
	parameter int REQ_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [1:0] min_sel,
	input wire logic [REQ_W-1:0] request_ns,
	output logic fire_q,
	output logic skip_q
);
	initial begin
		if (REQ_W < 8) begin
			$error("rcc_pulse_skip: request width must hold 40 ns");
		end
	end

	function automatic logic [7:0] min_width_ns(input logic [1:0] code);
		case (code)
			rcc_pkg::MINPW_OFF: min_width_ns = rcc_pkg::MINPW_NONE_NS;
			rcc_pkg::MINPW_CODE_10: min_width_ns = rcc_pkg::MINPW_10_NS;
			rcc_pkg::MINPW_CODE_20: min_width_ns = rcc_pkg::MINPW_20_NS;
			default: min_width_ns = rcc_pkg::MINPW_40_NS;
		endcase
	endfunction

	wire logic detect_on = (min_sel != rcc_pkg::MINPW_OFF);
	wire logic too_narrow = detect_on && (request_ns < REQ_W'(min_width_ns(min_sel)));
	wire logic fire_d = tick && !too_narrow;
	wire logic skip_d = tick && too_narrow;

	always_ff @(posedge clk) begin
		if (rst) begin
			fire_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			fire_q <= fire_d;
			skip_q <= skip_d;
		end
	end

	a_no_skip_off: assert property (@(posedge clk) disable iff (rst)
		tick && min_sel == rcc_pkg::MINPW_OFF |=> fire_q && !skip_q)
		else $error("pulse skipped while detection disabled");
	a_skip_narrow: assert property (@(posedge clk) disable iff (rst)
		tick && min_sel != rcc_pkg::MINPW_OFF
		&& request_ns < REQ_W'(min_width_ns(min_sel)) |=> skip_q && !fire_q)
		else $error("narrow pulse was not skipped whole");
	a_width_table: assert property (@(posedge clk) disable iff (rst)
		tick && min_sel == rcc_pkg::MINPW_CODE_20 && request_ns == REQ_W'(8'h13)
		##0 1'b1 |=> skip_q)
		else $error("20 ns minimum not applied");
endmodule

// ==== hw/rcc_top.sv ====
// Behaviour
// - Bit 7 picks oscillator or system clock
// - Divide field: one, one, four, eight
// - Divide field ignored on local oscillator
// - Bit 3 inverts divider input clock
// - Sync on: SAR clock inverted when bit4 zero
// - SAR invert bit ignored without sync
// - Sync aligns tracking and SAR to cycle
// - Width code zero disables pulse skipping
// - Width codes give 10, 20, 40 ns
// - Register at 0x97 page 0, resets 0x03
// - Too narrow pulse is skipped entirely
module rcc_top #(
	parameter int REQ_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_q,
	input wire logic osc_in,
	input wire logic [REQ_W-1:0] pw_request_ns,
	output logic reg_clk_q,
	output logic reg_tick_q,
	output logic div_in_invert_q,
	output logic pulse_fire_q,
	output logic pulse_skip_q,
	output logic adc_sync_q,
	output logic adc_track_q,
	output logic sar_clk_q
);
	initial begin
		if (REQ_W < 8 || REQ_W > 16) begin
			$error("rcc_top: request width out of range");
		end
	end

	function automatic logic [3:0] div_ratio(input logic [1:0] code);
		case (code)
			rcc_pkg::DIV_CODE_4: div_ratio = rcc_pkg::DIV_RATIO_4;
			rcc_pkg::DIV_CODE_8: div_ratio = rcc_pkg::DIV_RATIO_8;
			default: div_ratio = rcc_pkg::DIV_RATIO_1;
		endcase
	endfunction

	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic act_sel_q;
	logic [1:0] act_div_q;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic osc_prev_q;

	// Register decode
	wire logic ctrl_hit = (sfr_page == rcc_pkg::CTRL_PAGE) && (sfr_addr == rcc_pkg::CTRL_ADDR);
	wire logic ctrl_write = sfr_wr && ctrl_hit;
	wire logic ctrl_read = sfr_rd && ctrl_hit;
	wire logic [7:0] rdata_d = ctrl_read ? ctrl_q : 8'h00;

	// Register fields
	wire logic sel_sys = ctrl_q[rcc_pkg::SRC_SEL_BIT];
	wire logic [1:0] div_code = ctrl_q[rcc_pkg::DIV_HI:rcc_pkg::DIV_LO];
	wire logic sar_inv_bit = ctrl_q[rcc_pkg::SAR_INV_BIT];
	wire logic div_in_inv = ctrl_q[rcc_pkg::DIV_IN_INV_BIT];
	wire logic sync_en = ctrl_q[rcc_pkg::SYNC_EN_BIT];
	wire logic [1:0] minpw_code = ctrl_q[rcc_pkg::MINPW_HI:rcc_pkg::MINPW_LO];

	// Regulator period boundaries
	wire logic [3:0] act_lim = act_sel_q ? div_ratio(act_div_q) : rcc_pkg::DIV_RATIO_1;
	wire logic [3:0] new_lim = sel_sys ? div_ratio(div_code) : rcc_pkg::DIV_RATIO_1;
	wire logic osc_rise = osc_in && !osc_prev_q;
	wire logic sys_tick = act_sel_q && (cnt_q == 4'h0);
	wire logic tick_now = act_sel_q ? sys_tick : osc_rise;
	wire logic sys_high = (act_lim == rcc_pkg::DIV_RATIO_1) || (cnt_q < (act_lim >> 1));
	wire logic reg_clk_d = act_sel_q ? sys_high : osc_in;
	wire logic quiet_d = !reg_clk_d;
	wire logic sar_clk_d = sync_en && (sar_inv_bit ? reg_clk_d : !reg_clk_d);
	wire logic track_d = sync_en && quiet_d;

	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_write) begin
			ctrl_d = sfr_wdata;
		end
	end

	always_comb begin
		cnt_d = 4'h0;
		if (tick_now) begin
			cnt_d = (new_lim == rcc_pkg::DIV_RATIO_1) ? 4'h0 : 4'h1;
		end else if (act_sel_q && cnt_q != act_lim - 4'h1) begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= rcc_pkg::CTRL_RESET;
			sfr_rdata_q <= 8'h00;
			osc_prev_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			sfr_rdata_q <= rdata_d;
			osc_prev_q <= osc_in;
		end
	end

	// New source, ratio and input inversion take effect only at a period boundary
	always_ff @(posedge clk) begin
		if (rst) begin
			act_sel_q <= 1'b0;
			act_div_q <= 2'h0;
			div_in_invert_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
			if (tick_now) begin
				act_sel_q <= sel_sys;
				act_div_q <= div_code;
				div_in_invert_q <= div_in_inv;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_clk_q <= 1'b0;
			reg_tick_q <= 1'b0;
			adc_sync_q <= 1'b0;
			adc_track_q <= 1'b0;
			sar_clk_q <= 1'b0;
		end else begin
			reg_clk_q <= reg_clk_d;
			reg_tick_q <= tick_now;
			adc_sync_q <= sync_en;
			adc_track_q <= track_d;
			sar_clk_q <= sar_clk_d;
		end
	end

	rcc_pulse_skip #(.REQ_W(REQ_W)) u_skip (
		.clk(clk),
		.rst(rst),
		.tick(tick_now),
		.min_sel(minpw_code),
		.request_ns(pw_request_ns),
		.fire_q(pulse_fire_q),
		.skip_q(pulse_skip_q)
	);

	a_reset_value: assert property (@(posedge clk)
		rst |=> ctrl_q == rcc_pkg::CTRL_RESET && sfr_rdata_q == 8'h00)
		else $error("control register reset value wrong");
	a_read_back: assert property (@(posedge clk) disable iff (rst)
		ctrl_write ##1 (sfr_rd && ctrl_hit && !sfr_wr) |=> sfr_rdata_q == $past(sfr_wdata, 2))
		else $error("register read does not return written value");
	a_osc_source: assert property (@(posedge clk) disable iff (rst)
		!act_sel_q && !osc_rise |=> !reg_tick_q)
		else $error("regulator tick without oscillator edge");
	a_div8_period: assert property (@(posedge clk) disable iff (rst)
		tick_now && sel_sys && div_code == rcc_pkg::DIV_CODE_8
		|=> !tick_now [*7] ##1 tick_now)
		else $error("divide by eight period wrong");
	a_div4_period: assert property (@(posedge clk) disable iff (rst)
		tick_now && sel_sys && div_code == rcc_pkg::DIV_CODE_4
		|=> !tick_now [*3] ##1 tick_now)
		else $error("divide by four period wrong");
	a_glitch_free: assert property (@(posedge clk) disable iff (rst)
		!tick_now |=> $stable(act_sel_q) && $stable(act_div_q))
		else $error("clock selection changed inside a period");
	a_sar_polarity: assert property (@(posedge clk) disable iff (rst)
		sync_en && !sar_inv_bit |=> sar_clk_q == !reg_clk_q)
		else $error("SAR clock not inverted in sync mode");
	a_sync_off: assert property (@(posedge clk) disable iff (rst)
		!sync_en |=> !sar_clk_q && !adc_track_q)
		else $error("ADC sync outputs active with sync off");
	a_track_quiet: assert property (@(posedge clk) disable iff (rst)
		adc_track_q |-> !reg_clk_q && adc_sync_q)
		else $error("tracking outside quiet interval");
	a_div1_period: assert property (@(posedge clk) disable iff (rst)
		tick_now && sel_sys && new_lim == rcc_pkg::DIV_RATIO_1 |=> tick_now)
		else $error("divide by one period wrong");
	a_div4_clock: assert property (@(posedge clk) disable iff (rst)
		tick_now && sel_sys && div_code == rcc_pkg::DIV_CODE_4
		|=> reg_clk_q ##1 reg_clk_q ##1 !reg_clk_q ##1 !reg_clk_q)
		else $error("divide by four clock shape wrong");
	a_osc_ticks: assert property (@(posedge clk) disable iff (rst)
		tick_now && !sel_sys |=> tick_now == osc_rise)
		else $error("oscillator period disturbed by divide field");
	a_write_lands: assert property (@(posedge clk) disable iff (rst)
		ctrl_write |=> ctrl_q == $past(sfr_wdata))
		else $error("register write not applied");
	a_other_write: assert property (@(posedge clk) disable iff (rst)
		sfr_wr && !ctrl_hit |=> $stable(ctrl_q))
		else $error("write to other location changed register");
	a_read_idle: assert property (@(posedge clk) disable iff (rst)
		!ctrl_read |=> sfr_rdata_q == 8'h00)
		else $error("read data not cleared");
	a_invert_take: assert property (@(posedge clk) disable iff (rst)
		tick_now |=> div_in_invert_q == $past(div_in_inv))
		else $error("divider input invert not applied at period start");
	a_invert_hold: assert property (@(posedge clk) disable iff (rst)
		!tick_now |=> $stable(div_in_invert_q))
		else $error("divider input invert changed inside a period");
	a_sar_plain: assert property (@(posedge clk) disable iff (rst)
		sync_en && sar_inv_bit |=> sar_clk_q == reg_clk_q)
		else $error("SAR clock inverted although invert bit set");
	a_sync_level: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> adc_sync_q == $past(sync_en))
		else $error("sync enable not passed to converter");
	a_track_low: assert property (@(posedge clk) disable iff (rst)
		sync_en && !reg_clk_d |=> adc_track_q)
		else $error("tracking missing in quiet interval");
	a_one_outcome: assert property (@(posedge clk) disable iff (rst)
		reg_tick_q |-> pulse_fire_q != pulse_skip_q)
		else $error("period without exactly one fire or skip");
	a_no_stray_pulse: assert property (@(posedge clk) disable iff (rst)
		!reg_tick_q |-> !pulse_fire_q && !pulse_skip_q)
		else $error("fire or skip outside a period start");
endmodule

// ==== testbench/rcc_far_model.sv ====
module rcc_far_model (
	input wire logic clk,
	input wire logic [7:0] req_in,
	output logic osc_in,
	output logic [7:0] pw_request_ns
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_q = 3'h0;
	// Local oscillator, free running, six cycles per period
	always @(posedge clk) begin
		cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
		osc_in <= cnt_q < 3'h3;
		pw_request_ns <= req_in;
	end
endmodule

// ==== testbench/dcdc_clock_sync_control_test.sv ====
module dcdc_clock_sync_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic rd_seen = 1'b0;
	logic [3:0] sfr_page = 4'h0;
	logic [4:0] sar_prescale = 5'h1f;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] req = 8'h00;
	logic [7:0] sfr_rdata_q, pw_request_ns, v, w, c;
	logic osc_in, reg_clk_q, reg_tick_q, div_in_invert_q, pulse_fire_q, pulse_skip_q;
	logic adc_sync_q, adc_track_q, sar_clk_q, sk;
	logic [7:0] exp_q[$];
	logic [7:0] cfg[3] = '{8'hc4, 8'hd4, 8'hd0};
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 32'h5685;
	int n;
	always #25 clk = ~clk;
	rcc_top u_rcc_top (.clk(clk), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
		.osc_in(osc_in), .pw_request_ns(pw_request_ns), .reg_clk_q(reg_clk_q),
		.reg_tick_q(reg_tick_q), .div_in_invert_q(div_in_invert_q), .pulse_fire_q(pulse_fire_q),
		.pulse_skip_q(pulse_skip_q), .adc_sync_q(adc_sync_q), .adc_track_q(adc_track_q),
		.sar_clk_q(sar_clk_q));
	rcc_far_model u_rcc_far_model (.clk(clk), .req_in(req), .osc_in(osc_in),
		.pw_request_ns(pw_request_ns));
	task chk(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task summarize;
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task acc(input logic wrt, input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
		sfr_page <= p;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= wrt;
		sfr_rd <= !wrt;
		if (!wrt) exp_q.push_back(d);
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		@(posedge clk);
	endtask
	// Read data is checked the cycle after the read strobe is taken
	always @(posedge clk) begin
		if (rd_seen) chk("read data", exp_q.pop_front(), sfr_rdata_q);
		rd_seen <= sfr_rd;
	end
	task tick;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (reg_tick_q !== 1'b1 && n < 60);
	endtask
	task period(input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		acc(1'b1, 4'h0, 8'h97, d);
		tick;
		tick;
		tick;
		chk("tick spacing", e, n[7:0]);
	endtask
	initial begin
		#(4000 * 50);
		num_errors++;
		summarize;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		acc(1'b0, 4'h0, 8'h97, 8'h03);
		acc(1'b0, 4'h0, 8'h96, 8'h00);
		acc(1'b1, 4'h2, 8'h97, 8'h5a);
		acc(1'b0, 4'h2, 8'h97, 8'h00);
		acc(1'b0, 4'h0, 8'h97, 8'h03);
		v = $random(seed);
		acc(1'b1, 4'h0, 8'h97, v);
		acc(1'b0, 4'h0, 8'h97, v);
		// Write followed directly by a read of the same register
		sfr_wdata <= ~v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		exp_q.push_back(~v);
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		period(8'h60, 8'h06);
		for (int i = 0; i < 4; i++) begin
			c = (i < 2) ? 8'h01 : (i == 2) ? 8'h04 : 8'h08;
			period({1'b1, i[1:0], 5'h00}, c);
		end
		period(8'hc8, 8'h04);
		chk("divider invert", 8'h01, {7'h00, div_in_invert_q});
		period(8'hc0, 8'h04);
		chk("divider invert", 8'h00, {7'h00, div_in_invert_q});
		for (int i = 0; i < 4; i++) begin
			c = i[7:0];
			w = (c == 1) ? rcc_pkg::MINPW_10_NS :
				(c == 2) ? rcc_pkg::MINPW_20_NS : rcc_pkg::MINPW_40_NS;
			period({6'h30, c[1:0]}, 8'h04);
			for (int j = 0; j < 3; j++) begin
				@(posedge clk);
				req <= (j == 0) ? w - 8'h01 : (j == 1) ? w : 8'($random(seed));
				@(posedge clk);
				sk = c != 0 && req < w;
				tick;
				tick;
				tick;
				chk("fire skip", {6'h00, sk, !sk},
					{6'h00, pulse_skip_q, pulse_fire_q});
			end
		end
		@(posedge clk);
		sar_prescale <= 5'h00;
		for (int i = 0; i < 3; i++) begin
			period(cfg[i], 8'h04);
			for (int k = 1; k <= 8; k++) begin
				@(negedge clk);
				chk("sync outputs", {5'h00, cfg[i][2],
					cfg[i][2] & (cfg[i][4] ~^ reg_clk_q), cfg[i][2] & !reg_clk_q},
					{5'h00, adc_sync_q, sar_clk_q, adc_track_q});
				chk("regulator clock", {7'h00, (k % 4) < 2}, {7'h00, reg_clk_q});
			end
		end
		// Reset in mid-run brings the register back to its reset value
		@(posedge clk);
		acc(1'b1, 4'h0, 8'h97, 8'hff);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		acc(1'b0, 4'h0, 8'h97, 8'h03);
		@(posedge clk);
		summarize;
	end
endmodule
